// [hdl/flash_reset_pkg.sv]
// constants for the flash reset sequencing host controller
package flash_reset_pkg;
    // clock period in ns
    localparam int CLK_PERIOD_NS = 100;
    // ns units per us
    localparam int NS_PER_US     = 1000;

    // printed minimum times
    localparam int CORE_SUPPLY_SETUP_TIME_US     = 300;
    localparam int IO_SUPPLY_SETUP_TIME_US       = 300;
    localparam int RESTART_HOLD_TIME_US          = 35;
    localparam int RESTART_PULSE_WIDTH_NS        = 200;
    localparam int RESTART_HIGH_TO_SELECT_GAP_NS = 50;
    localparam int SELECT_HIGH_PULSE_WIDTH_NS    = 20;

    // least times round up to whole cycles, never below one
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : min_cycles

    localparam int SUPPLY_SETUP_NS =
        (CORE_SUPPLY_SETUP_TIME_US > IO_SUPPLY_SETUP_TIME_US) ?
        CORE_SUPPLY_SETUP_TIME_US * NS_PER_US :
        IO_SUPPLY_SETUP_TIME_US * NS_PER_US;
    localparam int SUPPLY_SETUP_CYCLES = min_cycles(SUPPLY_SETUP_NS);
    localparam int HOLD_CYCLES  = min_cycles(RESTART_HOLD_TIME_US * NS_PER_US);
    localparam int PULSE_CYCLES = min_cycles(RESTART_PULSE_WIDTH_NS);
    localparam int GAP_CYCLES   = min_cycles(RESTART_HIGH_TO_SELECT_GAP_NS);
    localparam int SELECT_HIGH_CYCLES = min_cycles(SELECT_HIGH_PULSE_WIDTH_NS);

    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

    // sequencer states
    typedef enum logic [5:0] {
        ST_POWER_WAIT = 6'h01,
        ST_PULSE      = 6'h02,
        ST_HOLD       = 6'h04,
        ST_GAP        = 6'h08,
        ST_READY      = 6'h10,
        ST_SELECT_GAP = 6'h20
    } seq_state_t;
endpackage : flash_reset_pkg

// [hdl/wait_timer_if.sv]
// load and expiry signals between the sequencer and its wait timer
`timescale 1ns/1ps
interface wait_timer_if;
    logic                               load;
    logic [flash_reset_pkg::CNT_W-1:0]  count;
    logic                               done;
    modport owner (output load, output count, input done);
    modport timer (input load, input count, output done);
endinterface : wait_timer_if

// [hdl/wait_timer.sv]
// down-counting wait timer with a one-cycle load
`timescale 1ns/1ps
module wait_timer (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // control
    wait_timer_if.timer      tmr
);
    typedef struct packed {
        logic [flash_reset_pkg::CNT_W-1:0] left;
    } timer_state_t;

    timer_state_t cur;
    timer_state_t next_cur;

    always_comb begin
        next_cur = cur;
        if (tmr.load) begin
            next_cur.left = tmr.count;
        end else if (cur.left != flash_reset_pkg::CNT_ZERO) begin
            next_cur.left = cur.left - flash_reset_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            // out of reset already timing the supply setup wait
            cur.left <= flash_reset_pkg::CNT_W'(
                flash_reset_pkg::SUPPLY_SETUP_CYCLES);
        end else begin
            cur <= next_cur;
        end
    end

    // from the register only: a load-dependent done would loop through
    // the sequencer's combinational load decision
    assign tmr.done = (cur.left == flash_reset_pkg::CNT_ZERO);
endmodule : wait_timer

// [hdl/flash_reset_host.sv]
// host-side power-on and warm reset sequencer for a parallel flash
//
// Summary of operation
// - host gives a fresh chip-enable fall after cold reset before access.
// - optional power-up reset: pulse at least 200 ns, hold 35 us.
// - host keeps reset high 50 ns before chip enable goes low.
// - pulse width plus hold phase covers the reset hold time; the high-to-select gap follows release.
// - chip enable stays high at least 20 ns between accesses.
`timescale 1ns/1ps
module flash_reset_host (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic resetn,
    // user side
    input  wire logic por_reset_req,
    input  wire logic warm_reset_req,
    input  wire logic access_req,
    output logic      access_ready,
    output logic      reset_busy,
    output logic      device_busy,
    // flash pins
    output logic      flash_reset_n,
    output logic      flash_select_n,
    input  wire logic ready_busy_n
);
    typedef struct packed {
        flash_reset_pkg::seq_state_t st;
        logic                        reset_n;
        logic                        select_n;
    } host_state_t;

    host_state_t cur;
    host_state_t next_cur;
    wait_timer_if tmr ();

    wait_timer u_timer (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .tmr     (tmr)
    );

    // =========================================================
    // sequencer
    always_comb begin
        next_cur  = cur;
        tmr.load  = 1'b0;
        tmr.count = flash_reset_pkg::CNT_ZERO;
        unique case (cur.st)
            flash_reset_pkg::ST_POWER_WAIT: begin
                // controls are ignored by the device here, wait it out
                if (tmr.done) begin
                    if (!cur.reset_n) begin
                        // hold counted from end of supply setup
                        next_cur.st = flash_reset_pkg::ST_HOLD;
                        tmr.load    = 1'b1;
                        tmr.count   = flash_reset_pkg::CNT_W'(
                            flash_reset_pkg::HOLD_CYCLES);
                    end else begin
                        next_cur.st = flash_reset_pkg::ST_GAP;
                        tmr.load    = 1'b1;
                        tmr.count   = flash_reset_pkg::CNT_W'(
                            flash_reset_pkg::GAP_CYCLES);
                    end
                end
            end
            flash_reset_pkg::ST_PULSE: begin
                if (tmr.done) begin
                    next_cur.st = flash_reset_pkg::ST_HOLD;
                    tmr.load    = 1'b1;
                    // hold less pulse keeps pulse plus hold phase >= hold
                    tmr.count   = flash_reset_pkg::CNT_W'(
                        flash_reset_pkg::HOLD_CYCLES -
                        flash_reset_pkg::PULSE_CYCLES);
                end
            end
            flash_reset_pkg::ST_HOLD: begin
                if (tmr.done) begin
                    next_cur.reset_n = 1'b1;
                    next_cur.st      = flash_reset_pkg::ST_GAP;
                    tmr.load         = 1'b1;
                    tmr.count        = flash_reset_pkg::CNT_W'(
                        flash_reset_pkg::GAP_CYCLES);
                end
            end
            flash_reset_pkg::ST_GAP: begin
                // also waits for busy to clear, covering a cold rerun
                if (tmr.done && ready_busy_n) begin
                    next_cur.st = flash_reset_pkg::ST_READY;
                end
            end
            flash_reset_pkg::ST_READY: begin
                if (warm_reset_req) begin
                    next_cur.reset_n  = 1'b0;
                    next_cur.select_n = 1'b1;
                    next_cur.st       = flash_reset_pkg::ST_PULSE;
                    tmr.load          = 1'b1;
                    tmr.count         = flash_reset_pkg::CNT_W'(
                        flash_reset_pkg::PULSE_CYCLES);
                end else if (access_req && cur.select_n) begin
                    // fresh falling edge of select for each access
                    next_cur.select_n = 1'b0;
                end else if (!access_req && !cur.select_n) begin
                    next_cur.select_n = 1'b1;
                    next_cur.st       = flash_reset_pkg::ST_SELECT_GAP;
                    tmr.load          = 1'b1;
                    tmr.count         = flash_reset_pkg::CNT_W'(
                        flash_reset_pkg::SELECT_HIGH_CYCLES);
                end
            end
            flash_reset_pkg::ST_SELECT_GAP: begin
                if (tmr.done) begin
                    next_cur.st = flash_reset_pkg::ST_READY;
                end
            end
        endcase
        // power-on request restarts the whole cold sequence
        if (por_reset_req) begin
            next_cur.st           = flash_reset_pkg::ST_POWER_WAIT;
            next_cur.select_n     = 1'b1;
            tmr.load              = 1'b1;
            tmr.count             = flash_reset_pkg::CNT_W'(
                flash_reset_pkg::SUPPLY_SETUP_CYCLES);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cur.st           <= flash_reset_pkg::ST_POWER_WAIT;
            cur.reset_n      <= 1'b1;
            cur.select_n     <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // =========================================================
    // outputs
    assign flash_reset_n  = cur.reset_n;
    assign flash_select_n = cur.select_n;
    assign access_ready   = (cur.st == flash_reset_pkg::ST_READY) &&
                            !cur.select_n;
    assign reset_busy     = (cur.st != flash_reset_pkg::ST_READY) &&
                            (cur.st != flash_reset_pkg::ST_SELECT_GAP);
    assign device_busy    = !ready_busy_n;
endmodule : flash_reset_host

// [testbench/flash_reset_monitor.sv]
// port assertions for the flash reset sequencer
`timescale 1ns/1ps
module flash_reset_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // user side
    input wire logic por_reset_req,
    input wire logic warm_reset_req,
    input wire logic access_req,
    input wire logic access_ready,
    input wire logic reset_busy,
    input wire logic device_busy,
    // flash pins
    input wire logic flash_reset_n,
    input wire logic flash_select_n,
    input wire logic ready_busy_n
);
    // ==========
    // helper counts
    logic [15:0] low_cnt;
    logic [15:0] por_cnt;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            low_cnt <= 16'h0000;
            // reset release starts the supply setup wait as well
            por_cnt <= 16'h0000;
        end else begin
            low_cnt <= flash_reset_n ? 16'h0000 : low_cnt + 16'h0001;
            if (por_reset_req) begin
                por_cnt <= 16'h0000;
            end else if (por_cnt != 16'hFFFF) begin
                por_cnt <= por_cnt + 16'h0001;
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence rst_release;
        $rose(flash_reset_n);
    endsequence
    AST_PULSE_HOLD: assert property (rst_release |->
        low_cnt >= flash_reset_pkg::HOLD_CYCLES) else $error("reset short");
    AST_SEL_AFTER_RST: assert property ($fell(flash_select_n) |->
        flash_reset_n && $past(flash_reset_n)) else $error("select early");
    AST_NO_SEL_IN_RST: assert property (!flash_reset_n |->
        flash_select_n) else $error("select in reset");
    AST_COLD_WAIT: assert property (!flash_select_n |->
        por_cnt >= flash_reset_pkg::SUPPLY_SETUP_CYCLES)
        else $error("cold wait short");
    AST_FRESH_FALL: assert property ($fell(reset_busy) |->
        flash_select_n) else $error("select low at ready");
    AST_WAIT_READY: assert property ($fell(reset_busy) |->
        $past(ready_busy_n)) else $error("ready while busy");
    AST_DEV_BUSY: assert property (device_busy == !ready_busy_n)
        else $error("busy mirror");
    AST_WARM_START: assert property ($fell(flash_reset_n) |->
        reset_busy && flash_select_n) else $error("reset start");
endmodule : flash_reset_monitor
bind flash_reset_host flash_reset_monitor mon_u (.ref_clk(ref_clk),
    .resetn(resetn), .por_reset_req(por_reset_req),
    .warm_reset_req(warm_reset_req), .access_req(access_req),
    .access_ready(access_ready), .reset_busy(reset_busy),
    .device_busy(device_busy), .flash_reset_n(flash_reset_n),
    .flash_select_n(flash_select_n), .ready_busy_n(ready_busy_n));

// [testbench/flash_device_model.sv]
// behavioural flash reset and busy line
`timescale 1ns/1ps
module flash_device_model #(
    parameter int COLD = 3200,
    parameter int WARM = 300
) (
    // clock and pins
    input  wire logic ref_clk,
    input  wire logic flash_reset_n,
    input  wire logic flash_select_n,
    output logic      ready_busy_n
);
    // ==========
    // reset engine; select is never looked at
    int   cnt = COLD;
    logic prev_n = 1'b1;
    always @(posedge ref_clk) begin
        prev_n <= flash_reset_n;
        if (cnt > 0) begin
            cnt <= cnt - 1;
        end else if (prev_n && !flash_reset_n) begin
            cnt <= WARM;
        end
    end
    assign ready_busy_n = (cnt == 0) && flash_reset_n;
endmodule : flash_device_model

// [testbench/test_flash_reset_host.sv]
// self-checking bench for the flash reset sequencer
`timescale 1ns/1ps
module test_flash_reset_host;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic por_reset_req = 1'b0;
    logic warm_reset_req = 1'b0;
    logic access_req = 1'b0;
    logic access_ready, reset_busy, device_busy;
    logic flash_reset_n, flash_select_n, ready_busy_n;
    int   error_cnt = 0;
    int   cmp_count = 0;
    int   n;
    always #50 ref_clk = ~ref_clk;
    flash_reset_host dut_u (.ref_clk(ref_clk), .resetn(resetn),
        .por_reset_req(por_reset_req), .warm_reset_req(warm_reset_req),
        .access_req(access_req), .access_ready(access_ready),
        .reset_busy(reset_busy), .device_busy(device_busy),
        .flash_reset_n(flash_reset_n), .flash_select_n(flash_select_n),
        .ready_busy_n(ready_busy_n));
    flash_device_model dev_u (.ref_clk(ref_clk),
        .flash_reset_n(flash_reset_n), .flash_select_n(flash_select_n),
        .ready_busy_n(ready_busy_n));
    // ==========
    // helpers
    task automatic stop_test();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic check(input string what, input bit ok,
                         input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (!ok) begin
            error_cnt++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic wait_idle(output int c);
        c = 0;
        while (reset_busy !== 1'b0 && c < 4000) begin
            tick();
            c++;
        end
        check("reset busy", reset_busy === 1'b0, 0, reset_busy);
    endtask : wait_idle
    // ==========
    // scenarios
    task automatic t_startup();
        wait_idle(n);
        check("startup wait", n >= flash_reset_pkg::SUPPLY_SETUP_CYCLES,
              flash_reset_pkg::SUPPLY_SETUP_CYCLES, n);
        check("select idle", flash_select_n === 1'b1, 1, flash_select_n);
    endtask : t_startup
    task automatic t_access();
        access_req = 1'b1;
        for (n = 0; n < 10 && access_ready !== 1'b1; n++) tick();
        check("select", flash_select_n === 1'b0, 0, flash_select_n);
        check("reset pin", flash_reset_n === 1'b1, 1, flash_reset_n);
        check("access ready", access_ready === 1'b1, 1, access_ready);
        access_req = 1'b0;
        for (n = 0; n < 10 && flash_select_n !== 1'b1; n++) tick();
        check("ready drop", access_ready === 1'b0, 0, access_ready);
        access_req = 1'b1;
        for (n = 0; n < 10 && flash_select_n !== 1'b0; n++) tick();
        check("select high", n >= 1, 1, n);
        access_req = 1'b0;
        for (n = 0; n < 10 && flash_select_n !== 1'b1; n++) tick();
    endtask : t_access
    task automatic t_por();
        por_reset_req = 1'b1;
        tick();
        por_reset_req = 1'b0;
        wait_idle(n);
        check("cold wait", n >= flash_reset_pkg::SUPPLY_SETUP_CYCLES,
              flash_reset_pkg::SUPPLY_SETUP_CYCLES, n);
    endtask : t_por
    task automatic t_warm();
        warm_reset_req = 1'b1;
        tick();
        warm_reset_req = 1'b0;
        for (n = 0; n < 5 && flash_reset_n !== 1'b0; n++) tick();
        tick();
        check("busy in reset", device_busy === 1'b1, 1, device_busy);
        for (n = 1; n < 1000 && flash_reset_n === 1'b0; n++) tick();
        check("reset low", n >= flash_reset_pkg::HOLD_CYCLES,
              flash_reset_pkg::HOLD_CYCLES, n);
        wait_idle(n);
        check("select idle", flash_select_n === 1'b1, 1, flash_select_n);
        check("busy clear", device_busy === 1'b0, 0, device_busy);
    endtask : t_warm
    initial begin
        repeat (12000) @(posedge ref_clk);
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        #1 resetn = 1'b1;
        t_startup();
        t_access();
        t_por();
        t_warm();
        t_access();
        stop_test();
    end
endmodule : test_flash_reset_host
